// [include/lt_pkg.sv]
package lt_pkg;
    // register offsets
    localparam logic [7:0] OFS_GEN_CTRL = 8'h10;
    localparam logic [7:0] OFS_DET_CTRL = 8'h11;
    localparam logic [7:0] OFS_ARB_LOW  = 8'h12;
    localparam logic [7:0] OFS_ARB_MID  = 8'h13;
    localparam logic [7:0] OFS_ARB_HIGH = 8'h14;
    localparam logic [7:0] OFS_CODE_LEN = 8'h15;
    localparam logic [7:0] OFS_GEN_CODE = 8'h16;
    localparam logic [7:0] OFS_ACT_CODE = 8'h17;
    localparam logic [7:0] OFS_DEA_CODE = 8'h18;
    localparam logic [7:0] OFS_LOOP     = 8'h19;
    localparam logic [7:0] OFS_STATUS   = 8'h1A;
    // reset values
    localparam logic [7:0] RST_GEN_CTRL = 8'h00;
    localparam logic [7:0] RST_DET_CTRL = 8'h03;
    localparam logic [7:0] RST_ARB      = 8'h55;
    localparam logic [7:0] RST_CODE_LEN = 8'h01;
    localparam logic [7:0] RST_GEN_CODE = 8'h01;
    localparam logic [7:0] RST_ACT_CODE = 8'h01;
    localparam logic [7:0] RST_DEA_CODE = 8'h09;
    // field positions
    localparam int GEN_CK_BIT   = 6;
    localparam int GEN_SEL_LSB  = 4;
    localparam int GEN_DIR_BIT  = 3;
    localparam int GEN_INV_BIT  = 2;
    localparam int GEN_POLY_LSB = 0;
    localparam int DET_DIR_BIT  = 3;
    localparam int DET_INV_BIT  = 2;
    localparam int DET_SEL_LSB  = 0;
    localparam int GEN_LEN_LSB  = 4;
    localparam int ACT_LEN_LSB  = 2;
    localparam int DEA_LEN_LSB  = 0;
    localparam int LOOP_AUTO_BIT = 3;
    localparam int LOOP_ERR_BIT  = 5;
    // detector and timing figures
    localparam logic [4:0] ARB_LAST    = 5'h17;
    localparam logic [2:0] CODE_MIN    = 3'h4;
    localparam logic [4:0] SYNC_RUN    = 5'h18;
    localparam logic [2:0] LOSS_RUN    = 3'h4;
    localparam logic [3:0] QRSS_ZEROS  = 4'hE;
    localparam int LOOP_TIME_MS = 5100;
    localparam int CLK_KHZ      = 200000;
    localparam int LOOP_CYCLES  = LOOP_TIME_MS * CLK_KHZ / 1000 * 1000;
    typedef enum logic [1:0] {
        GEN_OFF = 2'h0, GEN_PRBS = 2'h1, GEN_ARB = 2'h2, GEN_INBAND = 2'h3
    } gen_mode_t;
    typedef enum logic [1:0] {
        DET_QRSS = 2'h0, DET_P15 = 2'h1, DET_P11 = 2'h2, DET_ARB = 2'h3
    } det_sel_t;
    typedef enum logic {LB_OFF = 1'b0, LB_ON = 1'b1} lb_state_t;
endpackage

// [logic/line_test_pattern.sv]
// What this block does
// [R01] receive generator clock: reference or recovered
// [R02] transmit generator clock: reference, transmit, or rz recovered in rz mode
// [R03] generator select: off, prbs, arbitrary, inband
// [R04] direction bit inserts into transmit or receive
// [R05] inversion flips prbs and arbitrary output
// [R06] polynomial field picks 20, 15, 11
// [R07] detector monitors receive or transmit path
// [R08] detector inverts monitored data when set
// [R09] detector select picks expected pattern
// [R10] 24-bit arbitrary pattern, bit 23 first
// [R11] generate code uses low 5..8 bits
// [R12] activate target uses low 5..8 bits
// [R13] deactivate target uses low 5..8 bits
// [R14] inband code sent msb down, repeating
// [R15] activate detector ends each code bit 0
// [R16] deactivate detector ends each code bit 0
// [R17] rising error-insert write corrupts one bit
// [R18] auto loopback after 5.1 s code
// [R19] customary polynomials, qrss zero suppression
// [R20] sync after clean run, flag errors
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module ib_match (
    input  wire logic       i_mclk,
    input  wire logic       i_rst,
    input  wire logic       i_stb,
    input  wire logic [7:0] i_hist,
    input  wire logic [7:0] i_code,
    input  wire logic [1:0] i_len,
    output logic            o_hit
);
    logic [3:0] gap_r;
    logic [7:0] mask;
    logic [3:0] last;
    logic       match;
    assign mask  = 8'hFF >> (2'h3 - i_len);
    assign last  = {2'h0, i_len} + {1'b0, lt_pkg::CODE_MIN};
    // newest bit sits at bit 0, so bit 0 of the code closes each instance
    assign match = ((i_hist ^ i_code) & mask) == 8'h00;
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            gap_r <= 4'h0;
            o_hit <= 1'b0;
        end else if (i_stb) begin
            if (match) begin
                o_hit <= gap_r == last;
                gap_r <= 4'h0;
            end else begin
                if (gap_r >= last)
                    o_hit <= 1'b0;
                if (gap_r != 4'hF)
                    gap_r <= gap_r + 4'h1;
            end
        end
    end
endmodule

module line_test_pattern #(
    parameter int unsigned LOOP_CYCLES = lt_pkg::LOOP_CYCLES
) (
    input  wire logic       i_mclk,
    input  wire logic       i_rst,
    input  wire logic       i_reference_clock,
    input  wire logic       i_rx_recovered_clock,
    input  wire logic       i_transmit_clock_in,
    input  wire logic       i_rz_recovered_clock,
    input  wire logic       i_tx_rz_mode,
    input  wire logic       i_tx_data,
    input  wire logic       i_rx_data,
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wr_data,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic [7:0]      o_rd_data,
    output logic            o_tx_data,
    output logic            o_rx_data,
    output logic            o_pattern_sync,
    output logic            o_pattern_error,
    output logic            o_loopback
);
    localparam int TW = $clog2(LOOP_CYCLES + 1);

    // pins: 0 ref, 1 rx clk, 2 tx clk, 3 rz clk, 4 rz mode, 5 tx data, 6 rx data
    logic [6:0] pin, s1_r, s2_r, s3_r, lvl_r, rise;
    assign pin = {i_rx_data, i_tx_data, i_tx_rz_mode, i_rz_recovered_clock,
                  i_transmit_clock_in, i_rx_recovered_clock, i_reference_clock};
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            s1_r  <= 7'h00;
            s2_r  <= 7'h00;
            s3_r  <= 7'h00;
            lvl_r <= 7'h00;
        end else begin
            s1_r  <= pin;
            s2_r  <= s1_r;
            s3_r  <= s2_r;
            lvl_r <= (s3_r & ~(s2_r ^ s3_r)) | (lvl_r & (s2_r ^ s3_r));
        end
    end
    assign rise = s3_r & ~(s2_r ^ s3_r) & ~lvl_r;

    logic [7:0]  gen_ctrl_r, det_ctrl_r, len_r, gcode_r, acode_r, dcode_r;
    logic [23:0] arb_r;
    logic        auto_lb_r, err_pend_r;
    lt_pkg::gen_mode_t mode;
    lt_pkg::det_sel_t  dsel;
    logic [1:0]  poly, glen;
    logic        gen_dir, det_dir, tx_stb, rx_stb, gen_stb, det_stb, det_bit;
    assign mode    = lt_pkg::gen_mode_t'(gen_ctrl_r[lt_pkg::GEN_SEL_LSB +: 2]); // [R03]
    assign dsel    = lt_pkg::det_sel_t'(det_ctrl_r[lt_pkg::DET_SEL_LSB +: 2]); // [R09]
    assign poly    = gen_ctrl_r[lt_pkg::GEN_POLY_LSB + 1] ? 2'h2
                   : gen_ctrl_r[lt_pkg::GEN_POLY_LSB +: 2]; // [R06]
    assign glen    = len_r[lt_pkg::GEN_LEN_LSB +: 2]; // [R11]
    assign gen_dir = gen_ctrl_r[lt_pkg::GEN_DIR_BIT];
    assign det_dir = det_ctrl_r[lt_pkg::DET_DIR_BIT];
    // rz mode takes its bit timing from the clock recovered from the rails
    assign tx_stb  = lvl_r[4] ? rise[3] : rise[2]; // [R02]
    assign rx_stb  = rise[1];
    assign gen_stb = !gen_ctrl_r[lt_pkg::GEN_CK_BIT] ? rise[0]
                   : (gen_dir ? rx_stb : tx_stb); // [R01] [R02]
    assign det_stb = det_dir ? tx_stb : rx_stb; // [R07]
    assign det_bit = (det_dir ? s3_r[5] : s3_r[6])
                   ^ det_ctrl_r[lt_pkg::DET_INV_BIT]; // [R08]

    // self-clearing error insert: set wins over the clear
    logic err_set, err_done;
    assign err_set  = i_wr && i_addr == lt_pkg::OFS_LOOP
                   && i_wr_data[lt_pkg::LOOP_ERR_BIT] && !err_pend_r;
    assign err_done = gen_stb && (mode == lt_pkg::GEN_PRBS || mode == lt_pkg::GEN_ARB);
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst)
            err_pend_r <= 1'b0;
        else if (err_set)
            err_pend_r <= 1'b1; // [R17]
        else if (err_done)
            err_pend_r <= 1'b0; // [R17]
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            gen_ctrl_r <= lt_pkg::RST_GEN_CTRL;
            det_ctrl_r <= lt_pkg::RST_DET_CTRL;
            arb_r      <= {3{lt_pkg::RST_ARB}};
            len_r      <= lt_pkg::RST_CODE_LEN;
            gcode_r    <= lt_pkg::RST_GEN_CODE;
            acode_r    <= lt_pkg::RST_ACT_CODE;
            dcode_r    <= lt_pkg::RST_DEA_CODE;
            auto_lb_r  <= 1'b0;
        end else if (i_wr) begin
            if (i_addr == lt_pkg::OFS_GEN_CTRL)
                gen_ctrl_r <= {1'b0, i_wr_data[6:0]};
            else if (i_addr == lt_pkg::OFS_DET_CTRL)
                det_ctrl_r <= {4'h0, i_wr_data[3:0]};
            else if (i_addr == lt_pkg::OFS_ARB_LOW)
                arb_r[7:0] <= i_wr_data;
            else if (i_addr == lt_pkg::OFS_ARB_MID)
                arb_r[15:8] <= i_wr_data;
            else if (i_addr == lt_pkg::OFS_ARB_HIGH)
                arb_r[23:16] <= i_wr_data;
            else if (i_addr == lt_pkg::OFS_CODE_LEN)
                len_r <= {2'h0, i_wr_data[5:0]}; // [R12] [R13]
            else if (i_addr == lt_pkg::OFS_GEN_CODE)
                gcode_r <= i_wr_data;
            else if (i_addr == lt_pkg::OFS_ACT_CODE)
                acode_r <= i_wr_data;
            else if (i_addr == lt_pkg::OFS_DEA_CODE)
                dcode_r <= i_wr_data;
            else if (i_addr == lt_pkg::OFS_LOOP)
                auto_lb_r <= i_wr_data[lt_pkg::LOOP_AUTO_BIT];
        end
    end

    function automatic logic fb(input logic [1:0] p, input logic [19:0] s);
        case (p)
            2'h0:    fb = s[19] ^ s[16]; // [R19]
            2'h1:    fb = s[14] ^ s[13]; // [R19]
            default: fb = s[10] ^ s[8]; // [R19]
        endcase
    endfunction

    // generator
    logic [19:0] prbs_r;
    logic [3:0]  zrun_r;
    logic [4:0]  aptr_r;
    logic [2:0]  iptr_r;
    logic [2:0]  ilast;
    logic        raw, zmask, pat, stall;
    assign raw   = fb(poly, prbs_r);
    // only an all-zero active window can stall; a running sequence never reaches it
    assign stall = poly == 2'h0 ? ~|prbs_r
                 : (poly == 2'h1 ? ~|prbs_r[14:0] : ~|prbs_r[10:0]); // [R19]
    assign zmask = poly == 2'h0 && zrun_r >= lt_pkg::QRSS_ZEROS; // [R19]
    assign ilast = {1'b0, glen} + lt_pkg::CODE_MIN;
    always_comb begin
        if (mode == lt_pkg::GEN_INBAND)
            pat = gcode_r[iptr_r]; // [R14]
        else
            pat = ((mode == lt_pkg::GEN_ARB) ? arb_r[aptr_r] : (raw | zmask))
                ^ gen_ctrl_r[lt_pkg::GEN_INV_BIT] ^ err_pend_r; // [R05] [R17]
    end
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            prbs_r <= 20'h00001;
            zrun_r <= 4'h0;
            aptr_r <= lt_pkg::ARB_LAST;
            iptr_r <= 3'h4;
        end else if (mode == lt_pkg::GEN_OFF) begin
            aptr_r <= lt_pkg::ARB_LAST;
            iptr_r <= ilast;
        end else if (gen_stb) begin
            prbs_r <= {prbs_r[18:0], raw | stall};
            zrun_r <= raw ? 4'h0 : (zrun_r == 4'hF ? zrun_r : zrun_r + 4'h1);
            aptr_r <= aptr_r == 5'h00 ? lt_pkg::ARB_LAST : aptr_r - 5'h01; // [R10]
            iptr_r <= iptr_r == 3'h0 ? ilast : iptr_r - 3'h1; // [R11] [R14]
        end
    end

    logic tx_ins, rx_ins;
    assign tx_ins = mode != lt_pkg::GEN_OFF && !gen_dir; // [R04]
    assign rx_ins = mode != lt_pkg::GEN_OFF && gen_dir; // [R04]
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst)
            o_tx_data <= 1'b0;
        else if (tx_ins ? gen_stb : tx_stb)
            o_tx_data <= tx_ins ? pat : s3_r[5];
    end
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst)
            o_rx_data <= 1'b0;
        else if (rx_ins ? gen_stb : rx_stb)
            o_rx_data <= rx_ins ? pat : s3_r[6];
    end

    // detector
    logic [23:0] hist_r;
    logic [4:0]  dptr_r, good_r;
    logic [3:0]  dzrun_r;
    logic [2:0]  bad_r;
    logic        is_arb, mis, lock, det_wr;
    assign is_arb = dsel == lt_pkg::DET_ARB;
    assign mis    = is_arb ? det_bit != arb_r[dptr_r]
                  : det_bit != fb(dsel, hist_r[19:0])
                    && !(dsel == lt_pkg::DET_QRSS && dzrun_r >= lt_pkg::QRSS_ZEROS);
    assign lock   = is_arb ? {hist_r[22:0], det_bit} == arb_r
                  : !mis && good_r == lt_pkg::SYNC_RUN - 5'h01;
    assign det_wr = i_wr && i_addr == lt_pkg::OFS_DET_CTRL;
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            hist_r  <= 24'h000000;
            dzrun_r <= 4'h0;
        end else if (det_stb) begin
            hist_r  <= {hist_r[22:0], det_bit};
            dzrun_r <= det_bit ? 4'h0 : (dzrun_r == 4'hF ? dzrun_r : dzrun_r + 4'h1);
        end
    end
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_pattern_sync  <= 1'b0;
            o_pattern_error <= 1'b0;
            dptr_r <= lt_pkg::ARB_LAST;
            good_r <= 5'h00;
            bad_r  <= 3'h0;
        end else begin
            o_pattern_error <= det_stb && o_pattern_sync && mis && !det_wr; // [R20]
            if (det_wr) begin
                o_pattern_sync <= 1'b0;
                good_r <= 5'h00;
            end else if (det_stb && !o_pattern_sync) begin
                good_r <= mis ? 5'h00 : good_r + 5'h01;
                dptr_r <= lt_pkg::ARB_LAST;
                bad_r  <= 3'h0;
                if (lock)
                    o_pattern_sync <= 1'b1; // [R20]
            end else if (det_stb) begin
                dptr_r <= dptr_r == 5'h00 ? lt_pkg::ARB_LAST : dptr_r - 5'h01; // [R10]
                bad_r  <= mis ? bad_r + 3'h1 : 3'h0;
                if (mis && bad_r == lt_pkg::LOSS_RUN - 3'h1) begin
                    o_pattern_sync <= 1'b0;
                    good_r <= 5'h00;
                end
            end
        end
    end

    logic act_hit, dea_hit;
    ib_match u_act (
        .i_mclk (i_mclk),
        .i_rst  (i_rst),
        .i_stb  (det_stb),
        .i_hist ({hist_r[6:0], det_bit}),
        .i_code (acode_r),
        .i_len  (len_r[lt_pkg::ACT_LEN_LSB +: 2]),
        .o_hit  (act_hit)
    ); // [R12] [R15]
    ib_match u_dea (
        .i_mclk (i_mclk),
        .i_rst  (i_rst),
        .i_stb  (det_stb),
        .i_hist ({hist_r[6:0], det_bit}),
        .i_code (dcode_r),
        .i_len  (len_r[lt_pkg::DEA_LEN_LSB +: 2]),
        .o_hit  (dea_hit)
    ); // [R13] [R16]

    // automatic loopback
    lt_pkg::lb_state_t lb_r;
    logic [TW-1:0] tmr_r;
    logic          hold;
    assign hold = auto_lb_r && (lb_r == lt_pkg::LB_OFF ? act_hit : dea_hit);
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            lb_r  <= lt_pkg::LB_OFF;
            tmr_r <= '0;
        end else if (!auto_lb_r) begin
            lb_r  <= lt_pkg::LB_OFF;
            tmr_r <= '0;
        end else if (!hold) begin
            tmr_r <= '0;
        end else if (tmr_r == TW'(LOOP_CYCLES)) begin
            tmr_r <= '0;
            case (lb_r)
                lt_pkg::LB_OFF: lb_r <= lt_pkg::LB_ON; // [R18]
                default:        lb_r <= lt_pkg::LB_OFF; // [R18]
            endcase
        end else begin
            tmr_r <= tmr_r + TW'(1);
        end
    end
    assign o_loopback = lb_r == lt_pkg::LB_ON;

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst)
            o_rd_data <= 8'h00;
        else if (!i_rd)
            o_rd_data <= 8'h00;
        else if (i_addr == lt_pkg::OFS_GEN_CTRL)
            o_rd_data <= gen_ctrl_r;
        else if (i_addr == lt_pkg::OFS_DET_CTRL)
            o_rd_data <= det_ctrl_r;
        else if (i_addr == lt_pkg::OFS_ARB_LOW)
            o_rd_data <= arb_r[7:0];
        else if (i_addr == lt_pkg::OFS_ARB_MID)
            o_rd_data <= arb_r[15:8];
        else if (i_addr == lt_pkg::OFS_ARB_HIGH)
            o_rd_data <= arb_r[23:16];
        else if (i_addr == lt_pkg::OFS_CODE_LEN)
            o_rd_data <= len_r;
        else if (i_addr == lt_pkg::OFS_GEN_CODE)
            o_rd_data <= gcode_r;
        else if (i_addr == lt_pkg::OFS_ACT_CODE)
            o_rd_data <= acode_r;
        else if (i_addr == lt_pkg::OFS_DEA_CODE)
            o_rd_data <= dcode_r;
        else if (i_addr == lt_pkg::OFS_LOOP)
            o_rd_data <= {2'h0, err_pend_r, 1'b0, auto_lb_r, 3'h0};
        else if (i_addr == lt_pkg::OFS_STATUS)
            o_rd_data <= {4'h0, o_loopback, dea_hit, act_hit, o_pattern_sync};
        else
            o_rd_data <= 8'h00;
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    sequence s_gen_step;
        gen_stb && mode != lt_pkg::GEN_OFF;
    endsequence
    sequence s_arb_lock;
        det_stb && !det_wr && !o_pattern_sync && is_arb && lock;
    endsequence

    a_tx_passthru: assert property ((tx_stb && !tx_ins) |=> o_tx_data == $past(s3_r[5])) // [R04]
        else $error("transmit data not passed through");
    a_rx_insert: assert property ((s_gen_step and rx_ins) |=> o_rx_data == $past(pat)) // [R04]
        else $error("receive path missed generated bit");
    a_err_once: assert property ((err_pend_r && err_done && !err_set) |=> !err_pend_r) // [R17]
        else $error("error insert not cleared");
    a_arb_wrap: assert property ((s_gen_step and aptr_r == 5'h00) |=> aptr_r == 5'h17) // [R10]
        else $error("arbitrary pointer did not wrap to bit 23");
    a_ib_wrap: assert property ((s_gen_step and iptr_r == 3'h0) |=> iptr_r == $past(ilast)) // [R14]
        else $error("inband pointer did not restart at top bit");
    a_det_lock: assert property (s_arb_lock |=> o_pattern_sync && dptr_r == 5'h17) // [R20]
        else $error("arbitrary detector did not lock");
    a_err_synced: assert property (o_pattern_error |-> $past(o_pattern_sync) && $past(mis)) // [R20]
        else $error("error flagged while out of sync");
    a_gen_inv: assert property ((s_gen_step and mode == lt_pkg::GEN_ARB and !err_pend_r) // [R05]
        |=> ($past(gen_dir) ? o_rx_data : o_tx_data)
            == ($past(arb_r[aptr_r]) ^ $past(gen_ctrl_r[lt_pkg::GEN_INV_BIT])))
        else $error("arbitrary output inversion wrong");
    a_loop_enter: assert property ((hold && lb_r == lt_pkg::LB_OFF // [R18]
        && tmr_r == TW'(LOOP_CYCLES)) |=> o_loopback)
        else $error("loopback not entered after hold time");
    a_loop_auto: assert property (!auto_lb_r |=> !o_loopback) // [R18]
        else $error("loopback active with auto disabled");
endmodule

`default_nettype wire

// [bench/line_side_model.sv]
`timescale 1ns/1ps
`default_nettype none

// far side of both paths: gated bit clocks, a repeating 24-bit stream per
// path, and a record of the last 24 bits the block put out on each path
module line_side_model #(
    parameter int HALF_NS = 100
) (
    input  wire logic [3:0]  i_clk_en,
    input  wire logic [23:0] i_pattern,
    input  wire logic [1:0]  i_invert,
    input  wire logic        i_loop,
    input  wire logic        i_tx_out,
    input  wire logic        i_rx_out,
    output logic             o_reference_clock,
    output logic             o_rx_recovered_clock,
    output logic             o_transmit_clock_in,
    output logic             o_rz_recovered_clock,
    output logic             o_tx_data,
    output logic             o_rx_data,
    output logic [23:0]      o_tx_seen,
    output logic [23:0]      o_rx_seen
);
    logic       bit_clk = 1'b0;
    logic [4:0] pos = 5'h17;

    // system clock rises at odd multiples of 2.5 ns, so bit edges never meet it
    always #(HALF_NS) bit_clk = ~bit_clk;

    // disabled clocks stand still rather than run free
    assign o_reference_clock    = bit_clk & i_clk_en[0];
    assign o_rx_recovered_clock = bit_clk & i_clk_en[1];
    assign o_transmit_clock_in  = bit_clk & i_clk_en[2];
    assign o_rz_recovered_clock = bit_clk & i_clk_en[3];
    assign o_tx_data = i_pattern[pos] ^ i_invert[0];
    // loop mode hands the block's own transmit output back as receive data
    assign o_rx_data = i_loop ? i_tx_out : i_pattern[pos] ^ i_invert[1];

    // data moves on the falling edge, half a bit away from the sampling edge
    always @(negedge bit_clk) begin
        pos <= (pos == 5'h00) ? 5'h17 : pos - 5'h01;
        o_tx_seen <= {o_tx_seen[22:0], i_tx_out};
        o_rx_seen <= {o_rx_seen[22:0], i_rx_out};
    end
endmodule

`default_nettype wire

// [bench/tb_line_test_pattern_gen_detect.sv]
`timescale 1ns/1ps
`default_nettype none

module tb_line_test_pattern_gen_detect;
    localparam logic [23:0] PAT = 24'hC3A5F1;
    logic        i_mclk = 1'b0;
    logic        i_rst = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wdat = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [3:0]  clk_en = 4'h0;
    logic [23:0] pat = 24'h000000;
    logic [1:0]  inv = 2'h0;
    logic        rz = 1'b0;
    logic [7:0]  rdat;
    logic        ref_ck, rx_ck, tx_ck, rz_ck, txd, rxd, tx_o, rx_o, sync, lpbk, perr_o;
    logic        loop = 1'b0;
    logic [23:0] tx_seen, rx_seen;
    int          errors = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    int          perr = 0;

    always #2.5 i_mclk = ~i_mclk;

    line_test_pattern #(.LOOP_CYCLES(200)) DUT (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_reference_clock(ref_ck),
        .i_rx_recovered_clock(rx_ck), .i_transmit_clock_in(tx_ck),
        .i_rz_recovered_clock(rz_ck), .i_tx_rz_mode(rz), .i_tx_data(txd),
        .i_rx_data(rxd), .i_addr(addr), .i_wr_data(wdat), .i_wr(wr), .i_rd(rd),
        .o_rd_data(rdat), .o_tx_data(tx_o), .o_rx_data(rx_o),
        .o_pattern_sync(sync), .o_pattern_error(perr_o), .o_loopback(lpbk));

    line_side_model far (
        .i_clk_en(clk_en), .i_pattern(pat), .i_invert(inv), .i_loop(loop),
        .i_tx_out(tx_o),
        .i_rx_out(rx_o), .o_reference_clock(ref_ck), .o_rx_recovered_clock(rx_ck),
        .o_transmit_clock_in(tx_ck), .o_rz_recovered_clock(rz_ck),
        .o_tx_data(txd), .o_rx_data(rxd), .o_tx_seen(tx_seen), .o_rx_seen(rx_seen));

    task automatic report_and_stop;
        $display("errors=%0d comparisons=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1) begin
            errors++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        addr <= a;
        wdat <= d;
        wr <= 1'b1;
        @(posedge i_mclk);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge i_mclk);
        rd <= 1'b0;
        #1;
        chk(rdat === exp, "register read value");
    endtask

    task automatic wait_bits(input int n);
        repeat (n * 40) @(posedge i_mclk);
    endtask

    task automatic set_line(input logic [3:0] e, input logic [23:0] p,
                            input logic [1:0] iv, input logic z);
        @(posedge i_mclk);
        clk_en <= e;
        pat <= p;
        inv <= iv;
        rz <= z;
    endtask

    // capture phase is unknown, so any rotation of the period counts
    function automatic logic is_rot(input logic [23:0] v, input logic [23:0] p);
        logic hit;
        hit = 1'b0;
        for (int k = 0; k < 24; k++) begin
            if (v === ((p << k) | (p >> (24 - k)))) hit = 1'b1;
        end
        return hit;
    endfunction

    task automatic t_registers;
        logic [7:0] ofs [9];
        logic [7:0] rv [9];
        ofs = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18};
        rv = '{8'h00, 8'h03, 8'h55, 8'h55, 8'h55, 8'h01, 8'h01, 8'h01, 8'h09};
        for (int k = 0; k < 9; k++) begin
            rd_chk(ofs[k], rv[k]);
        end
        rd_chk(8'h05, 8'h00);
        wr_reg(8'h11, 8'hFF);
        rd_chk(8'h11, 8'h0F);
        wr_reg(8'h11, 8'h03);
    endtask

    task automatic t_generate;
        logic [7:0]  ctl [6];
        logic [3:0]  en [6];
        logic [23:0] exp [6];
        // expectation alternates so a path that never strobes keeps stale data and fails
        ctl = '{8'h20, 8'h24, 8'h60, 8'h64, 8'h68, 8'h2C};
        en = '{4'h1, 4'h1, 4'h4, 4'h8, 4'h2, 4'h1};
        exp = '{PAT, ~PAT, PAT, ~PAT, PAT, ~PAT};
        wr_reg(8'h14, PAT[23:16]);
        wr_reg(8'h13, PAT[15:8]);
        wr_reg(8'h12, PAT[7:0]);
        for (int k = 0; k < 6; k++) begin
            set_line(en[k], 24'h000000, 2'h0, k == 3);
            wr_reg(8'h10, ctl[k]);
            wait_bits(30);
            chk(is_rot(ctl[k][3] ? rx_seen : tx_seen, exp[k]), "generated stream");
        end
        wr_reg(8'h10, 8'h00);
    endtask

    task automatic t_inband_gen;
        // upper code bits set and inversion on: neither may reach the line
        wr_reg(8'h15, 8'h10);
        wr_reg(8'h16, 8'hEC);
        set_line(4'h1, 24'h000000, 2'h0, 1'b0);
        wr_reg(8'h10, 8'h34);
        wait_bits(30);
        chk(is_rot(tx_seen, {4{6'h2C}}), "six-bit code stream");
        wr_reg(8'h15, 8'h30);
        wr_reg(8'h16, 8'hA7);
        wait_bits(30);
        chk(is_rot(tx_seen, {3{8'hA7}}), "eight-bit code stream");
        wr_reg(8'h10, 8'h00);
    endtask

    task automatic t_detect;
        logic [7:0] ctl [4];
        logic       exp [4];
        ctl = '{8'h03, 8'h07, 8'h0B, 8'h0F};
        exp = '{1'b0, 1'b1, 1'b1, 1'b0};
        // receive stream arrives inverted, transmit stream plain
        set_line(4'h6, PAT, 2'h2, 1'b0);
        for (int k = 0; k < 4; k++) begin
            wr_reg(8'h11, ctl[k]);
            wait_bits(60);
            chk(sync === exp[k], "detector sync state");
        end
        wr_reg(8'h11, 8'h03);
    endtask

    task automatic t_prbs;
        // generator on transmit, looped back by the far side into the receive detector
        logic [7:0] gctl [5];
        logic [7:0] dctl [5];
        logic       exp [5];
        int         n0;
        gctl = '{8'h10, 8'h11, 8'h11, 8'h13, 8'h12};
        dctl = '{8'h00, 8'h02, 8'h01, 8'h02, 8'h02};
        exp = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
        set_line(4'h3, 24'h000000, 2'h0, 1'b0);
        loop <= 1'b1;
        for (int k = 0; k < 5; k++) begin
            wr_reg(8'h10, gctl[k]);
            wr_reg(8'h11, dctl[k]);
            wait_bits(60);
            chk(sync === exp[k], "prbs sync state");
        end
        // one flipped bit: the bit itself plus the two taps of x11+x9+1 that reuse it
        n0 = perr;
        wr_reg(8'h19, 8'h20);
        wait_bits(30);
        chk(perr - n0 == 3 && sync === 1'b1, "single inserted error");
        rd_chk(8'h19, 8'h00);
        wr_reg(8'h10, 8'h00);
        loop <= 1'b0;
    endtask

    task automatic t_loopback;
        wr_reg(8'h15, 8'h05);
        wr_reg(8'h17, 8'h2C);
        wr_reg(8'h18, 8'h33);
        wr_reg(8'h19, 8'h08);
        set_line(4'h2, {4{6'h2C}}, 2'h0, 1'b0);
        wait_bits(3);
        chk(lpbk === 1'b0, "loopback entered early");
        wait_bits(30);
        chk(lpbk === 1'b1, "loopback not entered");
        set_line(4'h2, {4{6'h33}}, 2'h0, 1'b0);
        wait_bits(3);
        chk(lpbk === 1'b1, "loopback left early");
        wait_bits(30);
        chk(lpbk === 1'b0, "loopback not left");
    endtask

    initial begin
        repeat (12) @(posedge i_mclk);
        i_rst <= 1'b0;
        t_registers();
        t_generate();
        t_inband_gen();
        t_detect();
        t_prbs();
        t_loopback();
        report_and_stop();
    end

    // about 35000 cycles are needed; the ceiling leaves room for a slow lock
    always @(posedge i_mclk) begin
        cycles <= cycles + 1;
        if (perr_o === 1'b1)
            perr <= perr + 1;
        if (cycles == 60000) begin
            errors++;
            report_and_stop();
        end
    end
endmodule

`default_nettype wire
